// *** hdl/branch_target_pkg.sv ***
// constants, register map and enumerations for the branch target and bit address block
// assumes a 32-bit AHB-Lite register bus and a 24-bit program counter
`default_nettype none

package branch_target_pkg;

  localparam int          PC_WIDTH           = 24;
  localparam int          ADDR_WIDTH         = 8;

  // bit operand space
  localparam logic [7:0]  NATIVE_RAM_FIRST   = 8'h20;
  localparam logic [7:0]  NATIVE_RAM_LAST    = 8'h7F;
  localparam logic [7:0]  LEGACY_RAM_BASE    = 8'h20;
  localparam logic [7:0]  SFR_FIRST          = 8'h80;

  // forced upper byte for accumulator plus data pointer jumps
  localparam logic [7:0]  LEGACY_CODE_REGION = 8'hFF;

  // register byte offsets
  localparam logic [7:0]  BIT_SELECT_OFFSET  = 8'h00;
  localparam logic [7:0]  NEXT_PC_OFFSET     = 8'h04;
  localparam logic [7:0]  TARGET_OFFSET      = 8'h08;
  localparam logic [7:0]  INDIRECT_OFFSET    = 8'h0C;
  localparam logic [7:0]  FLAGS_OFFSET       = 8'h10;
  localparam logic [7:0]  COMPARE_OFFSET     = 8'h14;
  localparam logic [7:0]  COMMAND_OFFSET     = 8'h18;
  localparam logic [7:0]  BIT_RESULT_OFFSET  = 8'h1C;
  localparam logic [7:0]  PC_RESULT_OFFSET   = 8'h20;

  // field positions
  localparam int          BIT_LEGACY_POS     = 16;
  localparam int          BIT_VALUE_POS      = 24;
  localparam int          CARRY_POS          = 0;
  localparam int          AUX_POS            = 1;
  localparam int          OVERFLOW_POS       = 2;
  localparam int          NEGATIVE_POS       = 3;
  localparam int          ZERO_POS           = 4;
  localparam int          CMD_WORD_POS       = 8;
  localparam int          RES_SFR_POS        = 16;
  localparam int          RES_VALID_POS      = 17;
  localparam int          RES_TAKEN_POS      = 24;
  localparam int          RES_FAULT_POS      = 25;
  localparam int          RES_CLEAR_POS      = 26;

  // reset values and the word transfer size
  localparam logic [23:0] PC_RESET           = 24'h000000;
  localparam logic [4:0]  FLAGS_RESET        = 5'h00;
  localparam logic [2:0]  SIZE_WORD          = 3'h2;

  typedef enum logic [3:0] {
    xfer_none,
    xfer_relative,
    xfer_jump_if_bit_set,
    xfer_jump_if_bit_clear,
    xfer_jump_if_set_then_clear,
    xfer_compare_jump,
    xfer_short_absolute,
    xfer_long,
    xfer_extended,
    xfer_word_pointer,
    xfer_acc_data_pointer,
    xfer_compare_op
  } xfer_kind_type;

  typedef enum logic [3:0] {
    jump_equal,
    jump_not_equal,
    jump_above,
    jump_below,
    jump_above_or_same,
    jump_below_or_same,
    jump_signed_equal,
    jump_signed_not_equal,
    jump_signed_greater,
    jump_signed_less,
    jump_signed_greater_or_equal,
    jump_signed_less_or_equal
  } compare_cond_type;

endpackage : branch_target_pkg

`default_nettype wire

// *** hdl/bit_operand_resolver.sv ***
// resolves a bit operand to a byte location and bit position
// assumes operands are stable while the result is used; purely combinational
`default_nettype none

module bit_operand_resolver
  import branch_target_pkg::*;
(
  input  wire logic       legacy_mode,
  input  wire logic [7:0] operand,
  input  wire logic [2:0] position,
  output logic      [7:0] byte_location,
  output logic      [2:0] bit_position,
  output logic            in_sfr,
  output logic            valid
);

  always_comb
  begin
    if (legacy_mode)
    begin
      bit_position = operand[2:0];
      if (!operand[7])
        byte_location = LEGACY_RAM_BASE + {3'h0, operand[7:3]};
      else
        byte_location = {operand[7:3], 3'h0};
      valid = 1'b1;
    end
    else
    begin
      // native form: byte plus position, no linear number
      byte_location = operand;
      bit_position  = position;
      valid = (operand >= NATIVE_RAM_FIRST);
    end
    in_sfr = (byte_location >= SFR_FIRST);
  end

endmodule : bit_operand_resolver

`default_nettype wire

// *** hdl/branch_condition.sv ***
// judges whether a conditional control transfer is taken
// assumes flags hold whatever the last flag-writing instruction left
`default_nettype none

module branch_condition
  import branch_target_pkg::*;
(
  input  wire xfer_kind_type    kind,
  input  wire compare_cond_type cond,
  input  wire logic             carry_flag,
  input  wire logic             zero_flag,
  input  wire logic             negative_flag,
  input  wire logic             overflow_flag,
  input  wire logic             bit_value,
  output logic                  taken
);

  logic signed_less;
  logic cmp_taken;

  always_comb
  begin
    signed_less = negative_flag ^ overflow_flag;
    case (cond)
      jump_equal:                   cmp_taken = zero_flag;
      jump_not_equal:               cmp_taken = !zero_flag;
      jump_above:                   cmp_taken = !carry_flag && !zero_flag;
      jump_below:                   cmp_taken = carry_flag;
      jump_above_or_same:           cmp_taken = !carry_flag;
      jump_below_or_same:           cmp_taken = carry_flag || zero_flag;
      jump_signed_equal:            cmp_taken = zero_flag;
      jump_signed_not_equal:        cmp_taken = !zero_flag;
      jump_signed_greater:          cmp_taken = !signed_less && !zero_flag;
      jump_signed_less:             cmp_taken = signed_less;
      jump_signed_greater_or_equal: cmp_taken = !signed_less;
      jump_signed_less_or_equal:    cmp_taken = signed_less || zero_flag;
      default:                      cmp_taken = 1'b0;
    endcase
    case (kind)
      xfer_jump_if_bit_set:        taken = bit_value;
      xfer_jump_if_bit_clear:      taken = !bit_value;
      xfer_jump_if_set_then_clear: taken = bit_value;
      xfer_compare_jump:           taken = cmp_taken;
      default:                     taken = 1'b0;
    endcase
  end

endmodule : branch_condition

`default_nettype wire

// *** hdl/branch_target_and_bit_address.sv ***
// branch target and bit address unit with an AHB-Lite register slave
// assumes one AHB-Lite master, word-sized single transfers, one clock
`default_nettype none

module branch_target_and_bit_address
  import branch_target_pkg::*;
(
  input  wire logic                                 hclk,
  input  wire logic                                 hresetn,
  input  wire logic                                 hsel,
  input  wire logic [31:0]                          haddr,
  input  wire logic [1:0]                           htrans,
  input  wire logic                                 hwrite,
  input  wire logic [2:0]                           hsize,
  input  wire logic [31:0]                          hwdata,
  input  wire logic                                 hready,
  output logic      [31:0]                          hrdata,
  output logic                                      hreadyout,
  output logic                                      hresp,
  output logic      [branch_target_pkg::PC_WIDTH-1:0] program_counter,
  output logic                                      program_counter_load,
  output logic                                      jump_taken,
  output logic                                      bit_clear,
  output logic      [7:0]                           bit_byte_location,
  output logic      [2:0]                           bit_position
);

  // bus group
  logic                  wr_pend_q, wr_pend_d;
  logic [ADDR_WIDTH-1:0] wr_addr_q, wr_addr_d;
  logic [31:0]           hrdata_q,  hrdata_d;
  logic                  addr_phase;

  // register group
  logic [7:0]            bit_operand_q,  bit_operand_d;
  logic [2:0]            bit_select_q,   bit_select_d;
  logic                  legacy_mode_q,  legacy_mode_d;
  logic                  bit_value_q,    bit_value_d;
  logic [PC_WIDTH-1:0]   next_pc_q,      next_pc_d;
  logic [PC_WIDTH-1:0]   target_op_q,    target_op_d;
  logic [7:0]            accumulator_q,  accumulator_d;
  logic [15:0]           data_pointer_q, data_pointer_d;
  logic [4:0]            flags_q,        flags_d;
  logic [15:0]           cmp_left_q,     cmp_left_d;
  logic [15:0]           cmp_right_q,    cmp_right_d;
  xfer_kind_type         kind_q,         kind_d;
  compare_cond_type      cond_q,         cond_d;
  logic                  cmp_word_q,     cmp_word_d;
  logic                  exec_q,         exec_d;

  // output group
  logic [PC_WIDTH-1:0]   pc_q,           pc_d;
  logic                  pc_load_q,      pc_load_d;
  logic                  taken_q,        taken_d;
  logic                  clear_q,        clear_d;
  logic [7:0]            clear_byte_q,   clear_byte_d;
  logic [2:0]            clear_pos_q,    clear_pos_d;

  // decode results
  logic [7:0]            res_byte;
  logic [2:0]            res_pos;
  logic                  res_sfr;
  logic                  res_valid;
  logic                  cond_taken;
  logic [PC_WIDTH-1:0]   target;
  logic                  target_taken;
  logic                  block_fault;
  logic                  clear_request;
  logic [PC_WIDTH-1:0]   rel_ext;
  logic [16:0]           diff_word;
  logic [8:0]            diff_byte;
  logic [4:0]            cmp_flags;

  bit_operand_resolver u_resolver (
    .legacy_mode   (legacy_mode_q),
    .operand       (bit_operand_q),
    .position      (bit_select_q),
    .byte_location (res_byte),
    .bit_position  (res_pos),
    .in_sfr        (res_sfr),
    .valid         (res_valid)
  );

  branch_condition u_condition (
    .kind          (kind_q),
    .cond          (cond_q),
    .carry_flag    (flags_q[CARRY_POS]),
    .zero_flag     (flags_q[ZERO_POS]),
    .negative_flag (flags_q[NEGATIVE_POS]),
    .overflow_flag (flags_q[OVERFLOW_POS]),
    .bit_value     (bit_value_q),
    .taken         (cond_taken)
  );

  // target selection; relative targets wrap at 24 bits, the accumulator plus data pointer sum wraps at 16 bits
  always_comb
  begin
    rel_ext       = {{(PC_WIDTH-8){target_op_q[7]}}, target_op_q[7:0]};
    target        = next_pc_q;
    target_taken  = 1'b0;
    block_fault   = 1'b0;
    clear_request = 1'b0;
    case (kind_q)
      xfer_relative:
      begin
        target       = next_pc_q + rel_ext;
        target_taken = 1'b1;
      end
      xfer_jump_if_bit_set, xfer_jump_if_bit_clear, xfer_jump_if_set_then_clear, xfer_compare_jump:
      begin
        target_taken = cond_taken;
        if (cond_taken)
          target = next_pc_q + rel_ext;
        // a taken target outside the current 256-byte block is flagged, not blocked
        block_fault   = cond_taken && (target[PC_WIDTH-1:8] != next_pc_q[PC_WIDTH-1:8]);
        clear_request = cond_taken && (kind_q == xfer_jump_if_set_then_clear);
      end
      xfer_short_absolute:
      begin
        target       = {next_pc_q[PC_WIDTH-1:11], target_op_q[10:0]};
        target_taken = 1'b1;
      end
      xfer_long:
      begin
        target       = {next_pc_q[PC_WIDTH-1:16], target_op_q[15:0]};
        target_taken = 1'b1;
      end
      xfer_extended:
      begin
        target       = target_op_q;
        target_taken = 1'b1;
      end
      xfer_word_pointer:
      begin
        target       = {next_pc_q[PC_WIDTH-1:16], target_op_q[15:0]};
        target_taken = 1'b1;
      end
      xfer_acc_data_pointer:
      begin
        target       = {LEGACY_CODE_REGION, data_pointer_q + {8'h00, accumulator_q}};
        target_taken = 1'b1;
      end
      default:
      begin
        target       = next_pc_q;
        target_taken = 1'b0;
      end
    endcase
  end

  // compare: subtraction whose difference is thrown away
  always_comb
  begin
    diff_word = {1'b0, cmp_left_q} - {1'b0, cmp_right_q};
    diff_byte = {1'b0, cmp_left_q[7:0]} - {1'b0, cmp_right_q[7:0]};
    cmp_flags = flags_q;
    if (cmp_word_q)
    begin
      cmp_flags[CARRY_POS]    = diff_word[16];
      cmp_flags[OVERFLOW_POS] = (cmp_left_q[15] ^ cmp_right_q[15]) & (cmp_left_q[15] ^ diff_word[15]);
      cmp_flags[NEGATIVE_POS] = diff_word[15];
      cmp_flags[ZERO_POS]     = (diff_word[15:0] == 16'h0000);
    end
    else
    begin
      cmp_flags[CARRY_POS]    = diff_byte[8];
      cmp_flags[AUX_POS]      = (cmp_left_q[3:0] < cmp_right_q[3:0]);   // aux only for bytes
      cmp_flags[OVERFLOW_POS] = (cmp_left_q[7] ^ cmp_right_q[7]) & (cmp_left_q[7] ^ diff_byte[7]);
      cmp_flags[NEGATIVE_POS] = diff_byte[7];
      cmp_flags[ZERO_POS]     = (diff_byte[7:0] == 8'h00);
    end
  end

  // bus slave: zero wait states, read data registered for the data phase
  always_comb
  begin
    addr_phase = hsel && htrans[1] && hready;
    wr_pend_d  = addr_phase && hwrite && (hsize == SIZE_WORD);
    wr_addr_d  = haddr[ADDR_WIDTH-1:0];
    hrdata_d   = 32'h00000000;
    if (addr_phase && !hwrite)
    begin
      case (haddr[ADDR_WIDTH-1:0])
        BIT_SELECT_OFFSET: hrdata_d = {7'h00, bit_value_q, 7'h00, legacy_mode_q, 5'h00, bit_select_q, bit_operand_q};
        NEXT_PC_OFFSET:    hrdata_d = {8'h00, next_pc_q};
        TARGET_OFFSET:     hrdata_d = {8'h00, target_op_q};
        INDIRECT_OFFSET:   hrdata_d = {8'h00, data_pointer_q, accumulator_q};
        FLAGS_OFFSET:      hrdata_d = {27'h0000000, flags_q};
        COMPARE_OFFSET:    hrdata_d = {cmp_right_q, cmp_left_q};
        COMMAND_OFFSET:    hrdata_d = {23'h000000, cmp_word_q, cond_q, kind_q};
        BIT_RESULT_OFFSET: hrdata_d = {14'h0000, res_valid, res_sfr, 5'h00, res_pos, res_byte};
        PC_RESULT_OFFSET:  hrdata_d = {5'h00, clear_request, block_fault, target_taken, target};
        default:           hrdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q  <= 32'h00000000;
    end
    else
    begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      hrdata_q  <= hrdata_d;
    end
  end

  // software writes, then execution of the stored command one cycle later
  always_comb
  begin
    bit_operand_d  = bit_operand_q;
    bit_select_d   = bit_select_q;
    legacy_mode_d  = legacy_mode_q;
    bit_value_d    = bit_value_q;
    next_pc_d      = next_pc_q;
    target_op_d    = target_op_q;
    accumulator_d  = accumulator_q;
    data_pointer_d = data_pointer_q;
    flags_d        = flags_q;
    cmp_left_d     = cmp_left_q;
    cmp_right_d    = cmp_right_q;
    kind_d         = kind_q;
    cond_d         = cond_q;
    cmp_word_d     = cmp_word_q;
    exec_d         = 1'b0;
    if (wr_pend_q)
    begin
      case (wr_addr_q)
        BIT_SELECT_OFFSET:
        begin
          bit_operand_d = hwdata[7:0];
          bit_select_d  = hwdata[10:8];
          legacy_mode_d = hwdata[BIT_LEGACY_POS];
          bit_value_d   = hwdata[BIT_VALUE_POS];
        end
        NEXT_PC_OFFSET:  next_pc_d   = hwdata[PC_WIDTH-1:0];
        TARGET_OFFSET:   target_op_d = hwdata[PC_WIDTH-1:0];
        INDIRECT_OFFSET:
        begin
          accumulator_d  = hwdata[7:0];
          data_pointer_d = hwdata[23:8];
        end
        FLAGS_OFFSET:    flags_d = hwdata[4:0];
        COMPARE_OFFSET:
        begin
          cmp_left_d  = hwdata[15:0];
          cmp_right_d = hwdata[31:16];
        end
        COMMAND_OFFSET:
        begin
          kind_d     = xfer_kind_type'(hwdata[3:0]);
          cond_d     = compare_cond_type'(hwdata[7:4]);
          cmp_word_d = hwdata[CMD_WORD_POS];
          exec_d     = 1'b1;
        end
        default:
        begin
          exec_d = 1'b0;
        end
      endcase
    end
    if (exec_q && (kind_q == xfer_compare_op))
      flags_d = cmp_flags;
    if (exec_q && clear_request)
      bit_value_d = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      // constants only, so the async path stays clean
      bit_operand_q  <= 8'h00;
      bit_select_q   <= 3'h0;
      legacy_mode_q  <= 1'b0;
      bit_value_q    <= 1'b0;
      next_pc_q      <= PC_RESET;
      target_op_q    <= 24'h000000;
      accumulator_q  <= 8'h00;
      data_pointer_q <= 16'h0000;
      flags_q        <= FLAGS_RESET;
      cmp_left_q     <= 16'h0000;
      cmp_right_q    <= 16'h0000;
      kind_q         <= xfer_none;
      cond_q         <= jump_equal;
      cmp_word_q     <= 1'b0;
      exec_q         <= 1'b0;
    end
    else
    begin
      bit_operand_q  <= bit_operand_d;
      bit_select_q   <= bit_select_d;
      legacy_mode_q  <= legacy_mode_d;
      bit_value_q    <= bit_value_d;
      next_pc_q      <= next_pc_d;
      target_op_q    <= target_op_d;
      accumulator_q  <= accumulator_d;
      data_pointer_q <= data_pointer_d;
      flags_q        <= flags_d;
      cmp_left_q     <= cmp_left_d;
      cmp_right_q    <= cmp_right_d;
      kind_q         <= kind_d;
      cond_q         <= cond_d;
      cmp_word_q     <= cmp_word_d;
      exec_q         <= exec_d;
    end
  end

  // outputs to fetch: the pc holds its value between commands
  always_comb
  begin
    pc_d         = pc_q;
    pc_load_d    = 1'b0;
    taken_d      = 1'b0;
    clear_d      = 1'b0;
    clear_byte_d = clear_byte_q;
    clear_pos_d  = clear_pos_q;
    if (exec_q && (kind_q != xfer_compare_op) && (kind_q != xfer_none))
    begin
      pc_d      = target;
      pc_load_d = 1'b1;
      taken_d   = target_taken;
    end
    if (exec_q && clear_request)
    begin
      clear_d      = 1'b1;
      clear_byte_d = res_byte;
      clear_pos_d  = res_pos;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pc_q         <= PC_RESET;
      pc_load_q    <= 1'b0;
      taken_q      <= 1'b0;
      clear_q      <= 1'b0;
      clear_byte_q <= 8'h00;
      clear_pos_q  <= 3'h0;
    end
    else
    begin
      pc_q         <= pc_d;
      pc_load_q    <= pc_load_d;
      taken_q      <= taken_d;
      clear_q      <= clear_d;
      clear_byte_q <= clear_byte_d;
      clear_pos_q  <= clear_pos_d;
    end
  end

  // ready is a flop that leaves reset high; the slave never stalls
  logic hreadyout_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hreadyout_q <= 1'b1;
    else
      hreadyout_q <= 1'b1;
  end

  always_comb
  begin
    hrdata               = hrdata_q;
    hreadyout            = hreadyout_q;
    hresp                = 1'b0;
    program_counter      = pc_q;
    program_counter_load = pc_load_q;
    jump_taken           = taken_q;
    bit_clear            = clear_q;
    bit_byte_location    = clear_byte_q;
    bit_position         = clear_pos_q;
  end

endmodule : branch_target_and_bit_address

`default_nettype wire

// *** test/branch_target_props.sv ***
// port checker for the branch target unit
// assumes one clock domain and word writes only
`default_nettype none
module branch_target_props
  import branch_target_pkg::*;
(
  input wire logic                                   hclk,
  input wire logic                                   hresetn,
  input wire logic                                   hsel,
  input wire logic [31:0]                            haddr,
  input wire logic [1:0]                             htrans,
  input wire logic                                   hwrite,
  input wire logic [31:0]                            hwdata,
  input wire logic                                   hready,
  input wire logic [31:0]                            hrdata,
  input wire logic                                   hreadyout,
  input wire logic                                   hresp,
  input wire logic [branch_target_pkg::PC_WIDTH-1:0] program_counter,
  input wire logic                                   program_counter_load,
  input wire logic                                   jump_taken,
  input wire logic                                   bit_clear
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic rd_hit, cmd_hit;
  assign rd_hit = hsel && htrans[1] && hready && !hwrite;
  assign cmd_hit = hsel && htrans[1] && hready && hwrite && haddr[7:0] == COMMAND_OFFSET;
  // kind 11 only touches flags, so it is left out
  sequence s_cmd;
    cmd_hit ##1 (hwdata[3:0] != 4'h0 && hwdata[3:0] < 4'hB);
  endsequence
  sequence s_lone_read;
    rd_hit ##1 !rd_hit;
  endsequence
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_zero_wait: assert property (hreadyout)
    else $error("wait state inserted");
  a_taken_loads: assert property (jump_taken |-> program_counter_load)
    else $error("taken without load");
  a_clear_taken: assert property (bit_clear |-> jump_taken)
    else $error("clear without taken jump");
  a_pc_held: assert property (!$stable(program_counter) |-> program_counter_load)
    else $error("counter moved without load");
  a_load_cause: assert property (program_counter_load |-> $past(cmd_hit, 3))
    else $error("load without command");
  a_cmd_exec: assert property (s_cmd |=> ##1 program_counter_load)
    else $error("command not executed");
  a_rdata_idle: assert property (s_lone_read |=> hrdata == 32'h0)
    else $error("read data held too long");
endmodule : branch_target_props
bind branch_target_and_bit_address branch_target_props i_branch_target_props (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .program_counter, .program_counter_load,
  .jump_taken, .bit_clear);
`default_nettype wire

// *** test/fetch_model.sv ***
// fetch side model: follows redirects and bit clear requests
// assumes one-cycle pulses on the core clock
`default_nettype none
module fetch_model
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [23:0] program_counter,
  input  wire logic        program_counter_load,
  input  wire logic        jump_taken,
  input  wire logic        bit_clear,
  output logic      [23:0] fetch_addr,
  output logic      [7:0]  clear_count
);
  timeunit 1ns;
  timeprecision 1ns;
  // only a taken transfer redirects the queue
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      fetch_addr <= 24'h0;
      clear_count <= 8'h0;
    end
    else
    begin
      if (program_counter_load && jump_taken)
        fetch_addr <= program_counter;
      if (bit_clear)
        clear_count <= clear_count + 8'h1;
    end
endmodule : fetch_model
`default_nettype wire

// *** test/tb_top.sv ***
// self-checking bench for the branch target unit
// assumes zero wait states and a fetch model on the redirect outputs
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import branch_target_pkg::*;
  logic                hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]          htrans = 2'h0;
  logic [31:0]         haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic                hreadyout, hresp, program_counter_load, jump_taken, bit_clear;
  logic [PC_WIDTH-1:0] program_counter, fetch_addr;
  logic [7:0]          bit_byte_location, clear_count;
  logic [2:0]          bit_position;
  int                  n_fail = 0, n_tests = 0, cycles = 0;
  // taken, command, flags, target, expected counter
  logic [67:0]         rows [22] = '{
    68'h1_01_00_000080_1233D6, 68'h1_01_00_00007F_1234D5, 68'h1_06_00_0007FF_1237FF, 68'h1_07_00_00ABCD_12ABCD,
    68'h1_08_00_FEDCBA_FEDCBA, 68'h1_09_00_00BEEF_12BEEF, 68'h1_0A_00_000000_FF0008, 68'h1_02_00_000010_123466,
    68'h0_03_00_000010_000000, 68'h1_05_10_000010_123466, 68'h0_15_10_000010_000000, 68'h1_25_00_000010_123466,
    68'h1_35_01_000010_123466, 68'h0_45_01_000010_000000, 68'h1_55_10_000010_123466, 68'h0_85_10_000010_000000,
    68'h1_95_08_000010_123466, 68'h1_A5_0C_000010_123466, 68'h1_B5_04_000010_123466, 68'h0_75_10_000010_000000,
    68'h1_85_00_000010_123466, 68'h1_65_10_000010_123466};

  branch_target_and_bit_address i_branch_target_and_bit_address (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize(SIZE_WORD), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .program_counter,
    .program_counter_load, .jump_taken, .bit_clear, .bit_byte_location, .bit_position);
  fetch_model i_fetch_model (.hclk, .hresetn, .program_counter, .program_counter_load, .jump_taken, .bit_clear,
    .fetch_addr, .clear_count);

  always #50 hclk = ~hclk;

  task automatic wrap_up;
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer

  // bounded wait: a compare op may give no pulse at all
  task automatic run(input logic [31:0] cmd);
    xfer(1'b1, COMMAND_OFFSET, cmd);
    for (int i = 0; i < 6 && program_counter_load !== 1'b1; i++)
    begin
      @(posedge hclk);
      #1;
    end
  endtask : run

  task automatic probe(input logic [31:0] sel, input logic [17:0] exp);
    xfer(1'b1, BIT_SELECT_OFFSET, sel);
    xfer(1'b0, BIT_RESULT_OFFSET, 32'h0);
    check(rd[17:0], exp);
  endtask : probe

  // aux is checked too: word compares must leave it alone
  task automatic cmp(input logic [31:0] ops, input logic [8:0] cmd, input logic [4:0] exp);
    xfer(1'b1, COMPARE_OFFSET, ops);
    run({23'h0, cmd});
    xfer(1'b0, FLAGS_OFFSET, 32'h0);
    check(rd[4:0], exp);
  endtask : cmp

  initial
  begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
    check(program_counter, 24'h0);
    xfer(1'b1, NEXT_PC_OFFSET, 32'h0012_3456);
    xfer(1'b1, INDIRECT_OFFSET, 32'h00FF_F810);
    xfer(1'b1, BIT_SELECT_OFFSET, 32'h0100_0523);
    foreach (rows[i])
    begin
      xfer(1'b1, FLAGS_OFFSET, {24'h0, rows[i][55:48]});
      xfer(1'b1, TARGET_OFFSET, {8'h0, rows[i][47:24]});
      run({24'h0, rows[i][63:56]});
      check(jump_taken, rows[i][64]);
      if (rows[i][64])
        check(program_counter, rows[i][23:0]);
    end
    run(32'h4);
    check({bit_clear, bit_byte_location, bit_position}, 12'h91D);
    xfer(1'b0, BIT_SELECT_OFFSET, 32'h0);
    check({clear_count, rd[24]}, 9'h002);
    check(fetch_addr, 24'h123466);
    run(32'h3);
    check(jump_taken, 1'b1);
    probe(32'h0001_001D, 18'h2_0523);
    probe(32'h0001_007F, 18'h2_072F);
    probe(32'h0001_008A, 18'h3_0288);
    probe(32'h0000_05FF, 18'h3_05FF);
    probe(32'h0000_077F, 18'h2_077F);
    probe(32'h0000_031F, 18'h0_031F);
    cmp(32'h0002_0001, 9'h10B, 5'h09);
    cmp(32'h0005_0005, 9'h10B, 5'h10);
    cmp(32'h0001_8000, 9'h10B, 5'h04);
    cmp(32'h0001_0010, 9'h00B, 5'h02);
    cmp(32'h0001_0000, 9'h00B, 5'h0B);
    // taken target leaves the 256-byte block: loaded, but flagged
    xfer(1'b1, FLAGS_OFFSET, 32'h10);
    xfer(1'b1, TARGET_OFFSET, 32'h80);
    run(32'h5);
    check(program_counter, 24'h1233D6);
    xfer(1'b0, PC_RESULT_OFFSET, 32'h0);
    check(rd, 32'h0312_33D6);
    xfer(1'b0, 8'h40, 32'h0);
    check(rd, 32'h0);
    hresetn <= 1'b0;
    @(posedge hclk);
    #1;
    check(program_counter, 24'h0);
    @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, NEXT_PC_OFFSET, 32'h0);
    check(rd, 32'h0);
    check({program_counter_load, program_counter}, 25'h0);
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
